// [design/option_port_controller.sv]
// Purpose: Drive the option connector pins for recorder or tone decoder options.
// Assumes: Pins and keys synchronous to aclk; software reaches registers by AXI4-Lite.
// Notes: Audio muting is a gate enable; the analog path sits outside.
`default_nettype none
module option_port_controller #(
  parameter int DEBOUNCE_COUNT = option_port_pkg::DEBOUNCE_CYCLES,
  parameter longint RECORD_COUNT = option_port_pkg::RECORD_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic record_key,
  input wire logic aux_key,
  input wire logic channel_step,
  input wire logic busy_in,
  input wire logic ptt_in,
  input wire logic hook_on,
  input wire logic transpond_ptt_in,
  input wire logic status_latch_in,
  input wire logic transmit_inhibit,
  output logic record_mode_out,
  output logic start_or_ptt_out,
  output logic stop_or_horn_out,
  output logic decoder_reset_out,
  output logic audio_pass,
  output logic transmit_on,
  output logic decode_latch
);
  typedef enum logic [3:0] {
    REC_IDLE = 4'h1,
    REC_ARMED = 4'h2,
    REC_RECORDING = 4'h4,
    REC_PLAYING = 4'h8
  } rec_state_type;
  rec_state_type rec_state_reg, rec_state_next;
  logic [1:0] option_reg;
  logic [63:0] rec_count_reg;
  logic [3:0] awaddr_reg, wstrb_reg, wa, ws;
  logic [31:0] wdata_reg, wd;
  logic unmuted_reg, inhibit_en_reg, horn_reg, record_mode_reg, start_reg, stop_reg, done_reg;
  logic sw_record_reg, sw_aux_reg, sw_channel_reg, aw_seen_reg, w_seen_reg;
  logic record_press, aux_press, chan_press, clear_active, chan_pulse_active;
  logic is_recorder, is_decoder, write_fire, end_of_operation;
  logic rec_db, aux_db, chan_db;
  // ==========================================================================
  // Key debouncing; software key strobes bypass the filter.
  // debounced key presses
  key_debounce #(.COUNT(DEBOUNCE_COUNT)) u_rec_db (
    .aclk(aclk), .aresetn(aresetn), .key_in(record_key), .press_pulse(rec_db));
  key_debounce #(.COUNT(DEBOUNCE_COUNT)) u_aux_db (
    .aclk(aclk), .aresetn(aresetn), .key_in(aux_key), .press_pulse(aux_db));
  // The encoder step is already a clean strobe, so only the edge matters.
  key_debounce #(.COUNT(1)) u_chan_db (
    .aclk(aclk), .aresetn(aresetn), .key_in(channel_step), .press_pulse(chan_db));
  assign record_press = rec_db || sw_record_reg;
  assign aux_press = aux_db || sw_aux_reg;
  assign chan_press = chan_db || sw_channel_reg;
  assign is_recorder = (option_reg == option_port_pkg::OPT_RECORDER);
  assign is_decoder = (option_reg == option_port_pkg::OPT_TWO_TONE) ||
                      (option_reg == option_port_pkg::OPT_MULTI_FREQ);
  assign end_of_operation = status_latch_in;
  // ==========================================================================
  // Recorder sequencer.
  always_comb begin
    rec_state_next = rec_state_reg;
    case (rec_state_reg)
      REC_IDLE: begin
        if (is_recorder && record_press) begin
          rec_state_next = REC_ARMED;
        end else if (is_recorder && aux_press) begin
          rec_state_next = REC_PLAYING;
        end
      end
      REC_ARMED: begin
        if (!is_recorder || aux_press) begin
          rec_state_next = REC_IDLE;
        end else if (busy_in) begin
          rec_state_next = REC_RECORDING;
        end
      end
      REC_RECORDING, REC_PLAYING: begin
        if (!is_recorder || aux_press || rec_count_reg >= RECORD_COUNT) begin
          rec_state_next = REC_IDLE;
        end else if (!done_reg && end_of_operation) begin
          rec_state_next = REC_IDLE;
        end
      end
      default: begin
        rec_state_next = REC_IDLE;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_state_reg <= REC_IDLE;
    end else begin
      rec_state_reg <= rec_state_next;
    end
  end
  // Tracks whether the recorder has acknowledged by pulling its status low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg <= 1'b1;
    end else if (rec_state_next != REC_RECORDING && rec_state_next != REC_PLAYING) begin
      done_reg <= 1'b1;
    end else if (!end_of_operation) begin
      done_reg <= 1'b0;
    end
  end
  // Safety bound on recording length in case the status never returns.
  always_ff @(posedge aclk) begin
    if (!aresetn || rec_state_reg != REC_RECORDING) begin
      rec_count_reg <= 64'h0;
    end else begin
      rec_count_reg <= rec_count_reg + 64'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record_mode_reg <= 1'b0;
    end else if (rec_state_reg == REC_IDLE && rec_state_next == REC_ARMED) begin
      record_mode_reg <= 1'b1;
    end else if (rec_state_reg == REC_IDLE && rec_state_next == REC_PLAYING) begin
      record_mode_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= (rec_state_next == REC_RECORDING) || (rec_state_next == REC_PLAYING);
    end
  end
  // stop strobe on aux during operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= aux_press && (rec_state_reg == REC_RECORDING || rec_state_reg == REC_PLAYING);
    end
  end
  pulse_timer #(.COUNT(option_port_pkg::CLEAR_PULSE_CYCLES)) u_clear (
    .aclk(aclk), .aresetn(aresetn),
    .start(rec_state_reg == REC_ARMED && rec_state_next == REC_RECORDING),
    .active(clear_active));
  pulse_timer #(.COUNT(option_port_pkg::RESET_PULSE_CYCLES)) u_chan (
    .aclk(aclk), .aresetn(aresetn), .start(chan_press && is_decoder),
    .active(chan_pulse_active));
  // ==========================================================================
  // Horn alert toggle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      horn_reg <= 1'b0;
    end else if (is_decoder && aux_press) begin
      horn_reg <= !horn_reg;
    end
  end
  // ==========================================================================
  // Pin multiplexing, registered so outputs come from flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record_mode_out <= 1'b0;
      start_or_ptt_out <= 1'b0;
      stop_or_horn_out <= 1'b0;
      decoder_reset_out <= 1'b1;
      audio_pass <= 1'b0;
      transmit_on <= 1'b0;
      decode_latch <= 1'b0;
    end else begin
      record_mode_out <= is_recorder && record_mode_reg;
      case (option_reg)
        option_port_pkg::OPT_RECORDER: start_or_ptt_out <= start_reg;
        option_port_pkg::OPT_TWO_TONE: start_or_ptt_out <= !transmit_on;
        option_port_pkg::OPT_MULTI_FREQ: start_or_ptt_out <= 1'b1;
        default: start_or_ptt_out <= 1'b0;
      endcase
      stop_or_horn_out <= is_recorder ? stop_reg : (is_decoder && horn_reg);
      if (is_recorder) begin
        decoder_reset_out <= !clear_active;
      end else begin
        decoder_reset_out <= chan_pulse_active ? 1'b1 : !hook_on;
      end
      audio_pass <= unmuted_reg || busy_in;
      transmit_on <= (ptt_in || (option_reg == option_port_pkg::OPT_MULTI_FREQ &&
                      !transpond_ptt_in)) && !(inhibit_en_reg && !transmit_inhibit);
      decode_latch <= is_decoder && !status_latch_in;
    end
  end
  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  assign s_axi_awready = !aw_seen_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_seen_reg && !s_axi_bvalid;
  assign write_fire = (aw_seen_reg || s_axi_awvalid) && (w_seen_reg || s_axi_wvalid) &&
                      !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen_reg <= 1'b0;
      w_seen_reg <= 1'b0;
    end else if (write_fire) begin
      aw_seen_reg <= 1'b0;
      w_seen_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end
  // Register update and write response.
  assign wa = aw_seen_reg ? awaddr_reg : s_axi_awaddr;
  assign wd = w_seen_reg ? wdata_reg : s_axi_wdata;
  assign ws = w_seen_reg ? wstrb_reg : s_axi_wstrb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_reg <= option_port_pkg::OPT_NONE;
      unmuted_reg <= 1'b0;
      inhibit_en_reg <= 1'b0;
      sw_record_reg <= 1'b0;
      sw_aux_reg <= 1'b0;
      sw_channel_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= option_port_pkg::RESP_OKAY;
    end else begin
      sw_record_reg <= 1'b0;
      sw_aux_reg <= 1'b0;
      sw_channel_reg <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (write_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= option_port_pkg::RESP_OKAY;
        if (wa == option_port_pkg::CTRL_OFFSET && ws[0]) begin
          option_reg <= wd[option_port_pkg::CTRL_OPT_LSB +: 2];
          unmuted_reg <= wd[option_port_pkg::CTRL_UNMUTED_BIT];
          inhibit_en_reg <= wd[option_port_pkg::CTRL_INHIBIT_EN_BIT];
        end else if (wa == option_port_pkg::KEY_OFFSET && ws[0]) begin
          sw_record_reg <= wd[option_port_pkg::KEY_RECORD_BIT];
          sw_aux_reg <= wd[option_port_pkg::KEY_AUX_BIT];
          sw_channel_reg <= wd[option_port_pkg::KEY_CHANNEL_BIT];
        end else if (wa != option_port_pkg::CTRL_OFFSET && wa != option_port_pkg::KEY_OFFSET) begin
          s_axi_bresp <= option_port_pkg::RESP_SLVERR;
        end
      end
    end
  end
  // ==========================================================================
  // AXI4-Lite read channel, answered one cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= option_port_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= option_port_pkg::RESP_OKAY;
      case (s_axi_araddr)
        option_port_pkg::CTRL_OFFSET:
          s_axi_rdata <= {28'h0, inhibit_en_reg, unmuted_reg, option_reg};
        option_port_pkg::STATUS_OFFSET:
          s_axi_rdata <= {24'h0, horn_reg, decode_latch, end_of_operation, transmit_on,
                          rec_state_reg};
        option_port_pkg::KEY_OFFSET: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= option_port_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ==========================================================================
  // Checks.
  sequence aux_in_op;
    aux_press && (rec_state_reg == REC_RECORDING || rec_state_reg == REC_PLAYING);
  endsequence
  chk_stop_on_aux: assert property (@(posedge aclk) disable iff (!aresetn)
    aux_in_op |=> stop_reg ##1 (is_recorder ? stop_or_horn_out : 1'b1))
    else $error("stop not raised after aux key");
  chk_horn_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    is_decoder && aux_press |=> horn_reg != $past(horn_reg))
    else $error("horn alert did not toggle");
  chk_hook_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    is_decoder && !chan_pulse_active && $stable(option_reg) |=> decoder_reset_out == !$past(hook_on))
    else $error("decoder reset not following hook");
  chk_chan_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    is_decoder && chan_press && $stable(option_reg) |=> ##1 decoder_reset_out)
    else $error("channel reset pulse missing");
  chk_clear_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_state_reg == REC_ARMED && rec_state_next == REC_RECORDING |=> ##1 !decoder_reset_out)
    else $error("recorder clear not pulsed");
  chk_record_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_state_reg == REC_IDLE && rec_state_next == REC_ARMED |=> record_mode_reg)
    else $error("record mode not selected");
  chk_play_start: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_state_reg == REC_IDLE && rec_state_next == REC_PLAYING |=> start_reg && !record_mode_reg)
    else $error("playback did not start");
  chk_audio_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !unmuted_reg && !busy_in |=> !audio_pass)
    else $error("muted audio passed without busy");
  chk_ptt_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    option_reg == option_port_pkg::OPT_TWO_TONE && $stable(option_reg)
      |=> start_or_ptt_out == !$past(transmit_on))
    else $error("ptt mirror wrong");
endmodule : option_port_controller
`default_nettype wire

// [design/option_port_pkg.sv]
// Purpose: Shared constants for the option connector controller.
// Assumes: One 250 MHz clock, synchronous active-low reset.
// Notes: Register map of the AXI4-Lite slave and timing figures live here.
`default_nettype none
package option_port_pkg;
  // ==========================================================================
  // Option selection codes.
  localparam logic [1:0] OPT_NONE = 2'h0;
  localparam logic [1:0] OPT_RECORDER = 2'h1;
  localparam logic [1:0] OPT_TWO_TONE = 2'h2;
  localparam logic [1:0] OPT_MULTI_FREQ = 2'h3;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] KEY_OFFSET = 4'h8;
  // Control register fields.
  localparam int CTRL_OPT_LSB = 0;
  localparam int CTRL_UNMUTED_BIT = 2;
  localparam int CTRL_INHIBIT_EN_BIT = 3;
  // Key strobe register fields, write one to press.
  localparam int KEY_RECORD_BIT = 0;
  localparam int KEY_AUX_BIT = 1;
  localparam int KEY_CHANNEL_BIT = 2;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Timing.
  localparam int CLK_MHZ = 250;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int CLEAR_PULSE_NS = 1000;
  localparam int CLEAR_PULSE_CYCLES = (CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECORD_S = 32;
  localparam longint RECORD_CYCLES = longint'(RECORD_S) * CLK_MHZ * 1000000;
endpackage : option_port_pkg
`default_nettype wire

// [design/key_debounce.sv]
// Purpose: Debounce one key level and emit a one-cycle press pulse.
// Assumes: Key input is synchronous to aclk, active high while pressed.
// Notes: A level must hold for the full count before it is accepted.
`default_nettype none
module key_debounce #(
  parameter int COUNT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic key_in,
  output logic press_pulse
);
  logic stable_reg;
  logic [31:0] count_reg;
  logic accept;
  assign accept = (key_in != stable_reg) && (count_reg >= 32'(COUNT - 1));
  // ==========================================================================
  // Count while the raw level differs from the accepted one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h0;
    end else if (key_in == stable_reg || accept) begin
      count_reg <= 32'h0;
    end else begin
      count_reg <= count_reg + 32'h1;
    end
  end
  // Accepted level; a press is its rising edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_reg <= 1'b0;
    end else if (accept) begin
      stable_reg <= key_in;
    end
  end
  assign press_pulse = accept && key_in;
endmodule : key_debounce
`default_nettype wire

// [design/pulse_timer.sv]
// Purpose: Hold a level for a fixed number of cycles after a start pulse.
// Assumes: Start is a one-cycle pulse.
// Notes: A start while active restarts the count.
`default_nettype none
module pulse_timer #(
  parameter int COUNT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic active
);
  logic [31:0] left_reg;
  // ==========================================================================
  // Down counter; active while nonzero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= 32'h0;
    end else if (start) begin
      left_reg <= 32'(COUNT);
    end else if (left_reg != 32'h0) begin
      left_reg <= left_reg - 32'h1;
    end
  end
  assign active = (left_reg != 32'h0);
endmodule : pulse_timer
`default_nettype wire

// [tb/option_board_model.sv]
// Purpose: Behavioural option board on the connector pins.
// Assumes: Pins change just after aclk rises.
// Notes: Recorder busy time is fixed by HOLD.
`default_nettype none
module option_board_model #(
  parameter int HOLD = 30
) (
  input wire logic aclk,
  input wire logic recorder,
  input wire logic start_pin,
  input wire logic match,
  input wire logic want_tx,
  output logic status_pin,
  output logic tx_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic last = 1'h0;
  // ==========================================================================
  // recorder busy time
  // A start edge holds the end flag low for HOLD cycles.
  always @(posedge aclk) begin
    last <= start_pin;
    if (recorder && start_pin && !last) cnt <= HOLD;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign status_pin = !(match || cnt > 0);
  // tones ride along: the transpond and alert audio is not modelled here.
  assign tx_req_n = !want_tx;
endmodule : option_board_model
`default_nettype wire

// [tb/test_option_port_controller.sv]
// Purpose: Self-checking bench for the option connector controller.
// Assumes: Short debounce and record counts.
// Notes: Pins are sampled 1 ns after an edge so updates have landed.
`default_nettype none
module test_option_port_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic record_key = 1'h0, aux_key = 1'h0, channel_step = 1'h0, busy_in = 1'h0;
  logic ptt_in = 1'h0, hook_on = 1'h1, transmit_inhibit = 1'h1, match = 1'h0;
  logic want_tx = 1'h0, rec_fit = 1'h0, transpond_ptt_in, status_latch_in;
  logic record_mode_out, start_or_ptt_out, stop_or_horn_out, decoder_reset_out;
  logic audio_pass, transmit_on, decode_latch;
  logic [6:0] pins;
  int miscompares = 0, samples_checked = 0;
  // Outputs gathered so one task can watch any of them.
  assign pins = {decode_latch, audio_pass, transmit_on, decoder_reset_out,
    stop_or_horn_out, start_or_ptt_out, record_mode_out};
  // Free-running clock.
  always #2 aclk = ~aclk;
  option_port_controller #(.DEBOUNCE_COUNT(2), .RECORD_COUNT(50)) uut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .record_key, .aux_key, .channel_step, .busy_in,
    .ptt_in, .hook_on, .transpond_ptt_in, .status_latch_in, .transmit_inhibit,
    .record_mode_out, .start_or_ptt_out, .stop_or_horn_out, .decoder_reset_out,
    .audio_pass, .transmit_on, .decode_latch);
  option_board_model board (.aclk, .recorder(rec_fit), .start_pin(start_or_ptt_out),
    .match, .want_tx, .status_pin(status_latch_in), .tx_req_n(transpond_ptt_in));
  // ==========================================================================
  // Verdict and comparison.
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task hang();
    miscompares++;
    conclude();
  endtask : hang
  // Readies are combinational, so they are sampled mid-cycle, before the edge.
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 200 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      wrsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end
    if (!tb) hang();
    @(posedge aclk); // An edge passes so the next call never reassigns bready at once.
  endtask : wr
  task rdw(input logic [3:0] a);
    logic ta, tr;
    tr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 200 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    if (!tr) hang();
    @(posedge aclk); // An edge passes so the next call never reassigns rready at once.
  endtask : rdw
  // Settled level check, after the lag of state and pin registers.
  task see(input int sel, input logic v);
    repeat (4) @(posedge aclk);
    #1 check(pins[sel], v);
    @(posedge aclk);
  endtask : see
  // Bounded wait for an output to reach a level.
  task until_pin(input int sel, input logic v);
    int n;
    #1;
    for (n = 0; n < 400 && pins[sel] !== v; n++) @(posedge aclk) #1;
    check(pins[sel], v);
    @(posedge aclk);
  endtask : until_pin
  // A key held well past the debounce count, then released.
  task press(input logic aux);
    aux_key <= aux;
    record_key <= !aux;
    repeat (6) @(posedge aclk);
    aux_key <= 1'h0;
    record_key <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask : press
  // ==========================================================================
  // Main sequence: decoder options, then the recorder.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    #1 check(pins, 7'h08);
    @(posedge aclk);
    #1 check(pins, 7'h00);
    @(posedge aclk);
    rdw(4'hc);
    check(rsp, option_port_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    wr(option_port_pkg::STATUS_OFFSET, 32'h0);
    check(wrsp, option_port_pkg::RESP_SLVERR);
    wr(option_port_pkg::CTRL_OFFSET, 32'h6);
    check(wrsp, option_port_pkg::RESP_OKAY);
    see(5, 1'h1);
    ptt_in <= 1'h1;
    see(1, 1'h0);
    ptt_in <= 1'h0;
    see(1, 1'h1);
    hook_on <= 1'h0;
    see(3, 1'h1);
    hook_on <= 1'h1;
    see(3, 1'h0);
    channel_step <= 1'h1;
    until_pin(3, 1'h1);
    until_pin(3, 1'h0);
    press(1'h1);
    see(2, 1'h1);
    press(1'h1);
    see(2, 1'h0);
    wr(option_port_pkg::KEY_OFFSET, 32'h2);
    see(2, 1'h1);
    match <= 1'h1;
    see(6, 1'h1);
    match <= 1'h0;
    wr(option_port_pkg::CTRL_OFFSET, 32'hb);
    want_tx <= 1'h1;
    see(4, 1'h1);
    transmit_inhibit <= 1'h0;
    see(4, 1'h0);
    want_tx <= 1'h0;
    transmit_inhibit <= 1'h1;
    wr(option_port_pkg::CTRL_OFFSET, 32'h1);
    rec_fit <= 1'h1;
    see(5, 1'h0);
    press(1'h0);
    see(0, 1'h1);
    see(1, 1'h0);
    busy_in <= 1'h1;
    until_pin(1, 1'h1);
    until_pin(3, 1'h0);
    rdw(option_port_pkg::STATUS_OFFSET);
    check({rd[5], rd[3:0]}, 5'h04);
    see(5, 1'h1);
    busy_in <= 1'h0;
    repeat (60) @(posedge aclk);
    rdw(option_port_pkg::STATUS_OFFSET);
    check(rd[3:0], 4'h1);
    press(1'h1);
    see(0, 1'h0);
    until_pin(1, 1'h1);
    fork
      press(1'h1);
      until_pin(2, 1'h1);
    join
    conclude();
  end
endmodule : test_option_port_controller
`default_nettype wire
